// File: hw/flash_host.sv
// Purpose: host-side sequencer that drives a parallel NOR flash through its pins
// Assumes: software orders operations over classic Wishbone, one flash command at a time
// Notes: status bits are sampled through two flops, so a read costs access time plus two
`timescale 1ns/100ps
`default_nettype none
module flash_host (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [31:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  output logic [23:0] FLASH_ADDR,
  output logic [15:0] FLASH_DQ_O,
  output logic FLASH_DQ_OE_N,
  input wire logic [15:0] FLASH_DQ_I,
  output logic FLASH_CE_N,
  output logic FLASH_OE_N,
  output logic FLASH_WE_N
);
  // ************************
  // helper functions
  // ************************
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [2:0] op_len(input flash_host_pkg::op_e op, input logic byp);
    unique case (op)
      flash_host_pkg::OP_BP_START: op_len = byp ? 3'd2 : 3'd4;
      flash_host_pkg::OP_ABORT_RESET: op_len = 3'd3;
      flash_host_pkg::OP_CHIP_ERASE: op_len = 3'd6;
      default: op_len = 3'd1;
    endcase
  endfunction

  function automatic flash_host_pkg::bus_cycle_s unlock(input logic second);
    unlock.addr = second ? flash_host_pkg::UL2_ADDR : flash_host_pkg::UL1_ADDR;
    unlock.data = second ? flash_host_pkg::CODE_55 : flash_host_pkg::CODE_AA;
  endfunction

  function automatic flash_host_pkg::bus_cycle_s op_step(input flash_host_pkg::op_e op, input logic [2:0] idx,
      input logic byp, input logic [23:0] blk, input logic [15:0] n, input logic [23:0] a, input logic [15:0] d);
    logic [2:0] k;
    k = (byp && op == flash_host_pkg::OP_BP_START) ? 3'(idx + 3'd2) : idx;
    op_step = unlock(k[0]);
    unique case (op)
      flash_host_pkg::OP_BP_START: begin
        if (k == 3'd2) op_step = '{blk, flash_host_pkg::CODE_25};
        if (k == 3'd3) op_step = '{blk, n};
      end
      flash_host_pkg::OP_BP_LOAD: op_step = '{a, d};
      flash_host_pkg::OP_BP_CONFIRM: op_step = '{blk, flash_host_pkg::CODE_29};
      flash_host_pkg::OP_ABORT_RESET: begin
        if (idx == 3'd2) op_step = '{flash_host_pkg::UL1_ADDR, flash_host_pkg::CODE_F0};
      end
      flash_host_pkg::OP_RESET: op_step = '{a, flash_host_pkg::CODE_F0};
      flash_host_pkg::OP_SUSPEND: op_step = '{a, flash_host_pkg::CODE_B0};
      flash_host_pkg::OP_RESUME: op_step = '{a, flash_host_pkg::CODE_30};
      flash_host_pkg::OP_CHIP_ERASE: begin
        // AA 55 80 AA 55 10
        if (idx == 3'd3) op_step = unlock(1'b0);
        if (idx == 3'd4) op_step = unlock(1'b1);
        if (idx == 3'd2) op_step = '{flash_host_pkg::UL1_ADDR, flash_host_pkg::CODE_80};
        if (idx == 3'd5) op_step = '{flash_host_pkg::UL1_ADDR, flash_host_pkg::CODE_10};
      end
      default: op_step = '{a, d};
    endcase
  endfunction

  // ************************
  // software registers
  // ************************
  logic ack_q;
  logic [31:0] dat_q;
  logic [1:0] ctrl_q;
  logic [23:0] addr_q;
  logic [15:0] data_q;
  logic [9:0] count_q;
  logic busy_q, refused_q, done_q, failed_q, aborted_q, misalign_q, loading_q, reread_q;
  logic [10:0] remain_q;
  logic [23:0] base_q, last_addr_q;
  logic last_d7_q;
  logic [15:0] rd_q, dq_s1_q, dq_s2_q;
  flash_host_pkg::seq_e state_q;
  flash_host_pkg::op_e op_q;
  logic [7:0] cnt_q;
  logic [2:0] idx_q;
  flash_host_pkg::pins_s pins_q;

  wire req = WB_CYC_I && WB_STB_I;
  wire wr_take = req && ack_q && WB_WE_I;
  wire [7:0] reg_a = WB_ADR_I[7:0];
  wire [31:0] wmerge = merge(32'h0000_0000, WB_DAT_I, WB_SEL_I);
  // byte lanes merge over the old value so a partial write keeps the other lanes
  wire [31:0] ctrl_m = merge({30'h0000_0000, ctrl_q}, WB_DAT_I, WB_SEL_I);
  wire [31:0] addr_m = merge({8'h00, addr_q}, WB_DAT_I, WB_SEL_I);
  wire [31:0] data_m = merge({16'h0000, data_q}, WB_DAT_I, WB_SEL_I);
  wire [31:0] count_m = merge({22'h00_0000, count_q}, WB_DAT_I, WB_SEL_I);
  wire cmd_wr = wr_take && reg_a == flash_host_pkg::REG_CMD;
  wire cmd_legal = wmerge[3:0] != 4'h0 && wmerge[3:0] <= flash_host_pkg::OP_LAST;
  wire flash_host_pkg::op_e cmd_op = flash_host_pkg::op_e'(wmerge[3:0]);
  wire bypass = ctrl_q[flash_host_pkg::CTRL_BYPASS_BIT];
  wire byte_mode = ctrl_q[flash_host_pkg::CTRL_BYTE_BIT];
  wire [10:0] buf_limit = byte_mode ? flash_host_pkg::BUF_LIMIT_X8 : flash_host_pkg::BUF_LIMIT_X16;
  wire over = {1'b0, count_q} >= buf_limit;
  wire same_region = byte_mode ? addr_q[23:10] == base_q[23:10] : addr_q[23:9] == base_q[23:9];
  wire refuse = busy_q || !cmd_legal
    || (cmd_op == flash_host_pkg::OP_BP_START && (loading_q || over))
    || (cmd_op == flash_host_pkg::OP_BP_LOAD && (!loading_q || remain_q == 11'h000))
    || (cmd_op == flash_host_pkg::OP_BP_LOAD && !same_region)
    || (cmd_op == flash_host_pkg::OP_BP_CONFIRM && (!loading_q || remain_q != 11'h000));
  wire accept = cmd_wr && !refuse;
  wire [31:0] status = {rd_q, 9'h000, loading_q, misalign_q, aborted_q, failed_q, done_q, refused_q, busy_q};

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= req && !ack_q;
      unique case (reg_a)
        flash_host_pkg::REG_CTRL: dat_q <= {30'h0000_0000, ctrl_q};
        flash_host_pkg::REG_ADDR: dat_q <= {8'h00, addr_q};
        flash_host_pkg::REG_DATA: dat_q <= {16'h0000, data_q};
        flash_host_pkg::REG_COUNT: dat_q <= {22'h00_0000, count_q};
        flash_host_pkg::REG_STATUS: dat_q <= status;
        default: dat_q <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_q <= flash_host_pkg::CTRL_RESET;
      addr_q <= 24'h00_0000;
      data_q <= 16'h0000;
      count_q <= 10'h000;
    end else if (wr_take) begin
      if (reg_a == flash_host_pkg::REG_CTRL) ctrl_q <= ctrl_m[1:0];
      if (reg_a == flash_host_pkg::REG_ADDR) addr_q <= addr_m[23:0];
      if (reg_a == flash_host_pkg::REG_DATA) data_q <= data_m[15:0];
      if (reg_a == flash_host_pkg::REG_COUNT) count_q <= count_m[9:0];
    end
  end

  // ************************
  // buffered program bookkeeping
  // ************************
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      loading_q <= 1'b0;
      remain_q <= 11'h000;
      base_q <= 24'h00_0000;
      last_addr_q <= 24'h00_0000;
      last_d7_q <= 1'b1;
      misalign_q <= 1'b0;
    end else if (accept) begin
      unique case (cmd_op)
        flash_host_pkg::OP_BP_START: begin
          loading_q <= 1'b1;
          remain_q <= 11'({1'b0, count_q} + 11'h001);
          base_q <= addr_q;
          misalign_q <= addr_q[8:0] != 9'h000;
        end
        flash_host_pkg::OP_BP_LOAD: begin
          remain_q <= 11'(remain_q - 11'h001);
          last_addr_q <= addr_q;
          last_d7_q <= data_q[flash_host_pkg::DATA_POLL_FLAG_BIT];
        end
        flash_host_pkg::OP_BP_CONFIRM, flash_host_pkg::OP_ABORT_RESET, flash_host_pkg::OP_RESET: begin
          loading_q <= 1'b0;
        end
        flash_host_pkg::OP_CHIP_ERASE: begin
          // erased cells read as ones, so poll expects a set bit
          last_addr_q <= 24'h00_0000;
          last_d7_q <= 1'b1;
        end
        default: begin
        end
      endcase
    end
  end

  // ************************
  // flash bus sequencer
  // ************************
  wire [2:0] len = op_len(op_q, bypass);
  wire last_step = 3'(idx_q + 3'd1) >= len;
  wire [2:0] nxt_idx = (state_q == flash_host_pkg::S_IDLE) ? 3'd0 : 3'(idx_q + 3'd1);
  wire flash_host_pkg::bus_cycle_s step = op_step(op_q, nxt_idx, bypass, base_q, {6'h00, count_q}, addr_q, data_q);
  wire is_read = op_q == flash_host_pkg::OP_POLL || op_q == flash_host_pkg::OP_READ;
  wire [23:0] rd_addr = (op_q == flash_host_pkg::OP_POLL) ? last_addr_q : addr_q;
  wire rd_end = state_q == flash_host_pkg::S_RD && cnt_q == 8'h00;
  wire poll = op_q == flash_host_pkg::OP_POLL;
  wire pass = dq_s2_q[flash_host_pkg::DATA_POLL_FLAG_BIT] == last_d7_q;
  wire err = dq_s2_q[flash_host_pkg::ERROR_FLAG_BIT];
  wire abt = dq_s2_q[flash_host_pkg::ABORT_FLAG_BIT];
  // poll bit and error flag may move together, so one more look decides
  wire need_reread = poll && !pass && err && !reread_q;
  wire seq_end = (state_q == flash_host_pkg::S_WHI && cnt_q == 8'h00 && last_step) || (rd_end && !need_reread);

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      dq_s1_q <= 16'h0000;
      dq_s2_q <= 16'h0000;
      busy_q <= 1'b0;
      op_q <= flash_host_pkg::OP_NONE;
      reread_q <= 1'b0;
    end else begin
      dq_s1_q <= FLASH_DQ_I;
      dq_s2_q <= dq_s1_q;
      if (accept) begin
        busy_q <= 1'b1;
        op_q <= cmd_op;
        reread_q <= 1'b0;
      end else if (seq_end) begin
        busy_q <= 1'b0;
      end
      if (rd_end && need_reread) reread_q <= 1'b1;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_q <= flash_host_pkg::S_IDLE;
      cnt_q <= 8'h00;
      idx_q <= 3'd0;
      rd_q <= 16'h0000;
      pins_q <= '{24'h00_0000, 16'h0000, 1'b1, 1'b1, 1'b1, 1'b1};
    end else begin
      unique case (state_q)
        flash_host_pkg::S_IDLE: begin
          if (busy_q && is_read) begin
            state_q <= flash_host_pkg::S_RD;
            cnt_q <= flash_host_pkg::RD_CYC;
            pins_q <= '{rd_addr, pins_q.dq, 1'b1, 1'b0, 1'b0, 1'b1};
          end else if (busy_q) begin
            state_q <= flash_host_pkg::S_WLO;
            cnt_q <= flash_host_pkg::WP_CYC;
            idx_q <= 3'd0;
            pins_q <= '{step.addr, step.data, 1'b0, 1'b0, 1'b1, 1'b1};
          end
        end
        flash_host_pkg::S_WLO: begin
          // first cycle keeps write high so address and data settle first
          if (cnt_q == 8'h00) begin
            state_q <= flash_host_pkg::S_WHI;
            cnt_q <= flash_host_pkg::WH_CYC;
            pins_q.we_n <= 1'b1;
          end else begin
            cnt_q <= 8'(cnt_q - 8'h01);
            pins_q.we_n <= 1'b0;
          end
        end
        flash_host_pkg::S_WHI: begin
          if (cnt_q != 8'h00) begin
            cnt_q <= 8'(cnt_q - 8'h01);
          end else if (!last_step) begin
            state_q <= flash_host_pkg::S_WLO;
            cnt_q <= flash_host_pkg::WP_CYC;
            idx_q <= nxt_idx;
            pins_q.addr <= step.addr;
            pins_q.dq <= step.data;
          end else begin
            state_q <= flash_host_pkg::S_IDLE;
            pins_q.ce_n <= 1'b1;
            pins_q.dq_oe_n <= 1'b1;
          end
        end
        flash_host_pkg::S_RD: begin
          if (cnt_q != 8'h00) begin
            cnt_q <= 8'(cnt_q - 8'h01);
          end else begin
            state_q <= flash_host_pkg::S_IDLE;
            rd_q <= dq_s2_q;
            pins_q.oe_n <= 1'b1;
            pins_q.ce_n <= 1'b1;
          end
        end
      endcase
    end
  end

  // ************************
  // result flags
  // ************************
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      refused_q <= 1'b0;
      done_q <= 1'b0;
      failed_q <= 1'b0;
      aborted_q <= 1'b0;
    end else begin
      if (accept) begin
        refused_q <= 1'b0;
        done_q <= 1'b0;
        failed_q <= 1'b0;
        aborted_q <= 1'b0;
      end
      if (cmd_wr && refuse) refused_q <= 1'b1;
      if (rd_end && poll) begin
        // error means failure needing plain reset, abort needs abort-reset
        if (pass) done_q <= 1'b1;
        else if (err && reread_q) failed_q <= 1'b1;
        else if (!err && abt) aborted_q <= 1'b1;
      end
    end
  end

  assign WB_ACK_O = ack_q;
  assign WB_DAT_O = dat_q;
  assign FLASH_ADDR = pins_q.addr;
  assign FLASH_DQ_O = pins_q.dq;
  assign FLASH_DQ_OE_N = pins_q.dq_oe_n;
  assign FLASH_CE_N = pins_q.ce_n;
  assign FLASH_OE_N = pins_q.oe_n;
  assign FLASH_WE_N = pins_q.we_n;

  // ************************
  // checks
  // ************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  a_start_limit: assert property (accept && cmd_op == flash_host_pkg::OP_BP_START
    |=> loading_q && remain_q <= buf_limit) else $error("buffer count above limit");
  a_load_region: assert property (accept && cmd_op == flash_host_pkg::OP_BP_LOAD
    |-> addr_q[23:10] == base_q[23:10] && (byte_mode || addr_q[9] == base_q[9]))
    else $error("load outside start region");
  a_load_count: assert property (accept && cmd_op == flash_host_pkg::OP_BP_LOAD
    |=> remain_q == 11'($past(remain_q) - 11'h001)) else $error("load count not stepped");
  a_confirm_code: assert property ($fell(FLASH_WE_N) && op_q == flash_host_pkg::OP_BP_CONFIRM
    |-> FLASH_DQ_O == flash_host_pkg::CODE_29 && remain_q == 11'h000) else $error("bad confirm");
  a_unlock_first: assert property (state_q == flash_host_pkg::S_IDLE && busy_q && !bypass
    && op_q == flash_host_pkg::OP_BP_START |=> FLASH_DQ_O == flash_host_pkg::CODE_AA
    && FLASH_ADDR == flash_host_pkg::UL1_ADDR) else $error("missing first unlock");
  a_abort_code: assert property ($fell(FLASH_WE_N) && op_q == flash_host_pkg::OP_ABORT_RESET
    |-> FLASH_DQ_O == (idx_q == 3'd2 ? flash_host_pkg::CODE_F0 : idx_q[0] ? flash_host_pkg::CODE_55
    : flash_host_pkg::CODE_AA)) else $error("bad abort-reset write");
  a_erase_seq: assert property ($fell(FLASH_WE_N) && op_q == flash_host_pkg::OP_CHIP_ERASE
    && idx_q == 3'd5 |-> FLASH_DQ_O == flash_host_pkg::CODE_10) else $error("bad erase confirm");
  a_poll_reread: assert property (rd_end && need_reread
    |=> busy_q && reread_q && state_q == flash_host_pkg::S_IDLE ##1 state_q == flash_host_pkg::S_RD)
    else $error("error flag not rechecked");
  a_reset_clears: assert property (accept && cmd_op == flash_host_pkg::OP_RESET
    |=> !loading_q && busy_q) else $error("reset left loading");
  a_we_pulse: assert property ($fell(FLASH_WE_N) |-> !FLASH_WE_N [*5] ##1 FLASH_WE_N)
    else $error("write pulse width wrong");
  a_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack held two cycles");

  c_start: cover property (accept && cmd_op == flash_host_pkg::OP_BP_START);
  c_confirm: cover property (seq_end && op_q == flash_host_pkg::OP_BP_CONFIRM);
  c_erase: cover property (seq_end && op_q == flash_host_pkg::OP_CHIP_ERASE);
  c_aborted: cover property (rd_end && poll && !pass && abt);
endmodule
`default_nettype wire

// File: hw/flash_host_pkg.sv
// Purpose: shared constants and types for the NOR flash command host
// Assumes: 100 MHz CLK, word-wide flash bus of 16 bits, 24 address bits
// Notes: timing figures are plain defaults, tune them for the fitted part
package flash_host_pkg;
  // ************************
  // clock and pin timing
  // ************************
  localparam int CLK_MHZ = 100;
  localparam int T_WP_NS = 50;
  localparam int T_WH_NS = 30;
  localparam int T_ACC_NS = 120;
  localparam int SYNC_CYC = 2;
  localparam logic [7:0] WP_CYC = 8'((T_WP_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] WH_CYC = 8'((T_WH_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] RD_CYC = 8'((T_ACC_NS * CLK_MHZ + 999) / 1000 + SYNC_CYC);
  // ************************
  // register map and fields
  // ************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CMD = 8'h04;
  localparam logic [7:0] REG_ADDR = 8'h08;
  localparam logic [7:0] REG_DATA = 8'h0C;
  localparam logic [7:0] REG_COUNT = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  localparam int CTRL_BYPASS_BIT = 0;
  localparam int CTRL_BYTE_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam int ST_BUSY = 0;
  localparam int ST_REFUSED = 1;
  localparam int ST_DONE = 2;
  localparam int ST_FAILED = 3;
  localparam int ST_ABORTED = 4;
  localparam int ST_MISALIGN = 5;
  localparam int ST_LOADING = 6;
  // ************************
  // flash status bits
  // ************************
  localparam int ABORT_FLAG_BIT = 1;
  localparam int ERROR_FLAG_BIT = 5;
  localparam int TOGGLE_FLAG_BIT = 6;
  localparam int DATA_POLL_FLAG_BIT = 7;
  // ************************
  // command codes and buffer
  // ************************
  localparam logic [23:0] UL1_ADDR = 24'h00_0555;
  localparam logic [23:0] UL2_ADDR = 24'h00_02AA;
  localparam logic [15:0] CODE_AA = 16'h00AA;
  localparam logic [15:0] CODE_55 = 16'h0055;
  localparam logic [15:0] CODE_25 = 16'h0025;
  localparam logic [15:0] CODE_29 = 16'h0029;
  localparam logic [15:0] CODE_F0 = 16'h00F0;
  localparam logic [15:0] CODE_B0 = 16'h00B0;
  localparam logic [15:0] CODE_30 = 16'h0030;
  localparam logic [15:0] CODE_80 = 16'h0080;
  localparam logic [15:0] CODE_10 = 16'h0010;
  localparam logic [10:0] BUF_LIMIT_X16 = 11'h200;
  localparam logic [10:0] BUF_LIMIT_X8 = 11'h100;
  typedef enum logic [3:0] {
    OP_NONE, OP_BP_START, OP_BP_LOAD, OP_BP_CONFIRM, OP_ABORT_RESET, OP_RESET,
    OP_SUSPEND, OP_RESUME, OP_CHIP_ERASE, OP_POLL, OP_READ
  } op_e;
  localparam logic [3:0] OP_LAST = 4'hA;
  typedef enum logic [1:0] {S_IDLE = 2'b00, S_WLO = 2'b01, S_WHI = 2'b11, S_RD = 2'b10} seq_e;
  typedef struct packed {
    logic [23:0] addr;
    logic [15:0] data;
  } bus_cycle_s;
  typedef struct packed {
    logic [23:0] addr;
    logic [15:0] dq;
    logic dq_oe_n;
    logic ce_n;
    logic oe_n;
    logic we_n;
  } pins_s;
endpackage

// File: tb/flash_dev_model.sv
// Purpose: behavioural NOR flash seen at its pins
// Assumes: word-wide bus, array starts erased
// Notes: an operation stays busy for BUSY_POLLS minus one status reads
`timescale 1ns/100ps
`default_nettype none
module flash_dev_model #(
  parameter int BUSY_POLLS = 3
) (
  input wire logic [23:0] a,
  input wire logic [15:0] d,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  output logic [15:0] q,
  output logic q_en
);
  typedef enum logic [2:0] {M_RD, M_CNT, M_LD, M_CF, M_BSY, M_ABT, M_SUS, M_ERS} mode_e;
  mode_e m = M_RD;
  logic [15:0] mem [logic [23:0]];
  logic [15:0] bf [logic [23:0]];
  logic [23:0] st;
  logic [15:0] ld = 16'hFFFF;
  logic [10:0] left;
  logic tog = 1'b0;
  logic e80 = 1'b0;
  logic fst;
  int bl;
  initial q = 16'h0000;
  assign q_en = !ce_n && !oe_n;
  // ************************
  // command writes
  // ************************
  always @(posedge we_n) if (!ce_n) begin
    case (m)
      M_CNT: begin
        left = 11'(d) + 11'h001;
        fst = 1'b1;
        m = (d > 16'h01FF) ? M_ABT : M_LD;
      end
      M_LD: begin
        if (fst) st = a;
        fst = 1'b0;
        if (a[23:9] != st[23:9]) m = M_ABT;
        bf[a] = d;
        ld = d;
        left = left - 11'h001;
        if (m == M_LD && left == 11'h000) m = M_CF;
      end
      M_CF: if (d == 16'h0029) begin
        foreach (bf[i]) mem[i] = (mem.exists(i) ? mem[i] : 16'hFFFF) & bf[i];
        bl = BUSY_POLLS;
        m = M_BSY;
      end else m = M_ABT;
      M_BSY: if (d == 16'h00B0) m = M_SUS;
      // any other code leaves the suspend standing
      M_SUS: if (d == 16'h0030) m = M_BSY;
      M_ABT: if (d == 16'h00F0) m = M_RD;
      M_RD: begin
        if (d == 16'h0080) e80 = 1'b1;
        if (d == 16'h0025) begin
          bf.delete();
          m = M_CNT;
        end
        if (d == 16'h0010 && e80) begin
          mem.delete();
          ld = 16'hFFFF;
          e80 = 1'b0;
          bl = BUSY_POLLS;
          m = M_ERS;
        end
      end
      default: ; // erase in flight takes no command
    endcase
  end
  // ************************
  // bus reads
  // ************************
  // answer a moment after the strobe so the address launched on the same edge has landed
  always @(negedge oe_n) begin
    #1;
    if (!ce_n) begin
      tog = ~tog;
      if (m == M_BSY || m == M_ERS) bl = bl - 1;
      if ((m == M_BSY || m == M_ERS) && bl <= 0) m = M_RD;
      if (m == M_RD || m == M_SUS) q = mem.exists(a) ? mem[a] : 16'hFFFF;
      else q = {8'h00, ~ld[7], tog, 4'h0, m == M_ABT, 1'b0};
    end
  end
endmodule
`default_nettype wire

// File: tb/flash_host_tb.sv
// Purpose: self-checking bench for the flash command host
// Assumes: model stays busy for two status reads
// Notes: flash writes and register reads are checked against queues
`timescale 1ns/100ps
`default_nettype none
module flash_host_tb;
  logic CLK = 1'b0, RST_N = 1'b0, WB_CYC_I = 1'b0, WB_STB_I = 1'b0, WB_WE_I = 1'b0, WB_ACK_O;
  logic FLASH_DQ_OE_N, FLASH_CE_N, FLASH_OE_N, FLASH_WE_N, dq_en;
  logic [31:0] WB_ADR_I = 32'h0000_0000, WB_DAT_I = 32'h0000_0000, WB_DAT_O, q, wd, wm;
  logic [3:0] WB_SEL_I = 4'hF;
  logic [23:0] FLASH_ADDR, blk;
  logic [15:0] FLASH_DQ_O, dq_m, dv;
  logic [31:0] exp_d[$], exp_m[$];
  flash_host_pkg::bus_cycle_s exp_w[$];
  int err_total = 0, num_checks = 0, cycles = 0, i;
  // a released bus shows the inverse of its last value, never a friendly copy
  wire logic [15:0] dq_i = !FLASH_DQ_OE_N ? FLASH_DQ_O : dq_en ? dq_m : ~dq_m;
  always #5 CLK = ~CLK;
  flash_host u_flash_host (.CLK(CLK), .RST_N(RST_N), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
    .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O),
    .WB_ACK_O(WB_ACK_O), .FLASH_ADDR(FLASH_ADDR), .FLASH_DQ_O(FLASH_DQ_O), .FLASH_DQ_OE_N(FLASH_DQ_OE_N),
    .FLASH_DQ_I(dq_i), .FLASH_CE_N(FLASH_CE_N), .FLASH_OE_N(FLASH_OE_N), .FLASH_WE_N(FLASH_WE_N));
  flash_dev_model u_flash_dev_model (.a(FLASH_ADDR), .d(FLASH_DQ_O), .ce_n(FLASH_CE_N), .oe_n(FLASH_OE_N),
    .we_n(FLASH_WE_N), .q(dq_m), .q_en(dq_en));
  // ************************
  // checks and bus tasks
  // ************************
  task automatic cmp_rd(input logic [31:0] got, input logic [31:0] e);
    num_checks++;
    if (got !== e) begin
      err_total++;
      $display("ERROR %0t read %h want %h", $time, got, e);
    end
  endtask
  task automatic cmp_w(input flash_host_pkg::bus_cycle_s got, input flash_host_pkg::bus_cycle_s e);
    num_checks++;
    if (got !== e) begin
      err_total++;
      $display("ERROR %0t flash write %h want %h", $time, got, e);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    WB_CYC_I <= 1'b1;
    WB_STB_I <= 1'b1;
    WB_WE_I <= we;
    WB_ADR_I <= {24'h00_0000, a};
    WB_DAT_I <= d;
    do @(posedge CLK); while (WB_ACK_O !== 1'b1);
    q = WB_DAT_O;
    WB_CYC_I <= 1'b0;
    WB_STB_I <= 1'b0;
    @(posedge CLK);
  endtask
  task automatic stat(input logic [31:0] e, input logic [31:0] m);
    exp_d.push_back(e);
    exp_m.push_back(m);
    wb(1'b0, flash_host_pkg::REG_STATUS, 32'h0000_0000);
  endtask
  task automatic cmd(input flash_host_pkg::op_e op);
    wb(1'b1, flash_host_pkg::REG_CMD, {28'h000_0000, op});
    do stat(32'h0, 32'h0); while (q[flash_host_pkg::ST_BUSY] !== 1'b0);
  endtask
  task automatic sa(input logic [23:0] a);
    wb(1'b1, flash_host_pkg::REG_ADDR, {8'h00, a});
  endtask
  task automatic ew(input logic [23:0] a, input logic [15:0] d);
    exp_w.push_back({a, d});
  endtask
  task automatic ul;
    ew(flash_host_pkg::UL1_ADDR, flash_host_pkg::CODE_AA);
    ew(flash_host_pkg::UL2_ADDR, flash_host_pkg::CODE_55);
  endtask
  task automatic start(input logic [9:0] n);
    sa(blk);
    wb(1'b1, flash_host_pkg::REG_COUNT, {22'h0, n});
    ew(blk, flash_host_pkg::CODE_25);
    ew(blk, {6'h00, n});
    cmd(flash_host_pkg::OP_BP_START);
  endtask
  task automatic load(input logic [23:0] a, input logic [15:0] d);
    sa(a);
    wb(1'b1, flash_host_pkg::REG_DATA, {16'h0000, d});
    ew(a, d);
    cmd(flash_host_pkg::OP_BP_LOAD);
  endtask
  task automatic poll(input logic [31:0] e);
    do begin
      cmd(flash_host_pkg::OP_POLL);
      stat(32'h0, 32'h0);
    end while (q[4:2] === 3'b000);
    stat(e, 32'h0000_003F);
  endtask
  task automatic results;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ************************
  // watchers
  // ************************
  always @(posedge CLK) if (WB_ACK_O === 1'b1 && WB_WE_I === 1'b0) begin
    wd = exp_d.pop_front();
    wm = exp_m.pop_front();
    if (wm != 32'h0) cmp_rd(WB_DAT_O & wm, wd);
  end
  always @(posedge FLASH_WE_N) if (FLASH_CE_N === 1'b0) cmp_w({FLASH_ADDR, FLASH_DQ_O}, exp_w.pop_front());
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 60000) begin
      err_total++;
      results();
    end
  end
  initial begin
    void'($urandom(32'h789a_1a0b));
    repeat (20) @(posedge CLK);
    RST_N <= 1'b1;
    @(posedge CLK);
    stat(32'h0, 32'hFFFF_FFFF);
    exp_d.push_back(32'h0);
    exp_m.push_back(32'hFFFF_FFFF);
    wb(1'b0, 8'h40, 32'h0);
    blk = 24'($urandom) & 24'hFF_FE00;
    sa(blk);
    ul();
    start(10'h003);
    for (i = 0; i < 4; i++) begin
      dv = 16'($urandom);
      load(blk + 24'(i == 3 ? 1 : i), dv);
    end
    ew(blk, flash_host_pkg::CODE_29);
    cmd(flash_host_pkg::OP_BP_CONFIRM);
    poll(32'h0000_0004);
    sa(blk + 24'h1);
    cmd(flash_host_pkg::OP_READ);
    stat({dv, 16'h0}, 32'hFFFF_0000);
    for (i = 0; i < 2; i++) begin
      wb(1'b1, flash_host_pkg::REG_CTRL, 32'(2 * i));
      wb(1'b1, flash_host_pkg::REG_COUNT, 32'(i == 1 ? 256 : 512));
      cmd(flash_host_pkg::OP_BP_START);
      stat(32'h2, 32'h2);
    end
    wb(1'b1, flash_host_pkg::REG_CTRL, 32'h0);
    ul();
    start(10'h000);
    load(blk, dv);
    ew(blk, flash_host_pkg::CODE_F0);
    cmd(flash_host_pkg::OP_RESET);
    poll(32'h0000_0010);
    ul();
    ew(flash_host_pkg::UL1_ADDR, flash_host_pkg::CODE_F0);
    cmd(flash_host_pkg::OP_ABORT_RESET);
    stat(32'h0, 32'h10);
    wb(1'b1, flash_host_pkg::REG_CTRL, 32'h1);
    start(10'h001);
    sa(blk + 24'h200);
    cmd(flash_host_pkg::OP_BP_LOAD);
    stat(32'h2, 32'h2);
    load(blk + 24'h2, 16'($urandom));
    load(blk + 24'h3, dv);
    ew(blk, flash_host_pkg::CODE_29);
    cmd(flash_host_pkg::OP_BP_CONFIRM);
    ew(blk + 24'h3, flash_host_pkg::CODE_B0);
    cmd(flash_host_pkg::OP_SUSPEND);
    sa(blk ^ 24'h10_0000);
    cmd(flash_host_pkg::OP_READ);
    stat(32'hFFFF_0000, 32'hFFFF_0000);
    sa(blk + 24'h3);
    ew(blk + 24'h3, flash_host_pkg::CODE_30);
    cmd(flash_host_pkg::OP_RESUME);
    poll(32'h0000_0004);
    wb(1'b1, flash_host_pkg::REG_CTRL, 32'h0);
    ul();
    ew(flash_host_pkg::UL1_ADDR, flash_host_pkg::CODE_80);
    ul();
    ew(flash_host_pkg::UL1_ADDR, flash_host_pkg::CODE_10);
    cmd(flash_host_pkg::OP_CHIP_ERASE);
    ew(blk + 24'h3, flash_host_pkg::CODE_B0);
    cmd(flash_host_pkg::OP_SUSPEND);
    poll(32'h0000_0004);
    cmd(flash_host_pkg::OP_READ);
    stat(32'hFFFF_0000, 32'hFFFF_0000);
    cmp_rd(32'(exp_w.size()), 32'h0);
    results();
  end
endmodule
`default_nettype wire
